// [rtl/rapd_top.sv]
// Per-phase current and voltage RMS, active power and total power with an Avalon-MM register file
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps

module rapd_top (
  input wire logic i_clk_sys,                   // Master clock, 50 MHz
  input wire logic i_rst_n,                     // Async reset, active low
  input rapd_pkg::rapd_avs_req_t i_avs,         // Avalon-MM request
  output logic [31:0] o_avs_readdata,           // Avalon-MM read data
  output logic o_avs_waitrequest,               // Avalon-MM wait request
  input rapd_pkg::rapd_cur_smp_t i_cur,         // Current samples A/B/C
  input rapd_pkg::rapd_volt_smp_t i_volt        // Voltage waveform samples A/B/C
);
  import rapd_pkg::*;

  rapd_state_t s_q, s_d;

  logic tick;
  logic [1:0] sum_mode;
  logic [2:0] sum_sel;
  logic signed [23:0] cur_s [3];
  logic signed [15:0] volt_s [3];
  logic signed [25:0] cur_g [3];
  logic signed [15:0] volt_g [3];
  logic signed [47:0] cur_sq [3];
  logic signed [31:0] volt_sq [3];
  logic signed [25:0] term [3];
  logic signed [41:0] prod [3];
  logic signed [29:0] pwr_in [3];
  logic signed [47:0] ms_i [3];
  logic signed [31:0] ms_v [3];
  logic signed [29:0] pwr [3];
  logic [47:0] sq_in_i [3];
  logic [47:0] sq_in_v [3];
  logic [23:0] root_i [3];
  logic [23:0] root_v [3];
  logic done_i [3];
  logic done_v [3];

  // ==========================================================================
  // Rate divider
  // ==========================================================================
  assign tick = (s_q.div == DIV_LAST);
  assign sum_mode = s_q.mode[MODE_SUM_LSB+1:MODE_SUM_LSB];
  assign sum_sel = {s_q.mode[MODE_SEL_A-2], s_q.mode[MODE_SEL_A-1], s_q.mode[MODE_SEL_A]};

  // ==========================================================================
  // Per-phase datapath
  // ==========================================================================
  for (genvar g = 0; g < 3; g++) begin : g_ph
    // Gain and squaring of the raw samples
    assign cur_s[g] = $signed(i_cur.ph[g]);
    assign volt_s[g] = $signed(i_volt.ph[g]);
    assign cur_g[g] = rapd_gain_mul(cur_s[g], s_q.pgain[g]);
    assign volt_g[g] = rapd_sat16(rapd_gain_mul(24'(volt_s[g]), s_q.per_phase_voltage_gain[g]));
    // Operands widened first so the square is not cut at the sample width
    assign cur_sq[g] = 48'(cur_s[g]) * 48'(cur_s[g]);
    assign volt_sq[g] = 32'(volt_g[g]) * 32'(volt_g[g]);

    // Instantaneous power; the current side already carries the power gain
    assign prod[g] = 42'(volt_s[g]) * 42'(term[g]);
    assign pwr_in[g] = prod[g][PWR_SHIFT+29:PWR_SHIFT];

    rapd_lpf #(.W(48)) u_lpf_i (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_en(tick),
      .i_x(cur_sq[g]),
      .o_y(ms_i[g])
    );

    rapd_lpf #(.W(32)) u_lpf_v (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_en(tick),
      .i_x(volt_sq[g]),
      .o_y(ms_v[g])
    );

    // DC part of the instantaneous power is the phase active power
    rapd_lpf #(.W(30)) u_lpf_p (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_en(tick),
      .i_x(pwr_in[g]),
      .o_y(pwr[g])
    );

    // Gain on the mean square gives the square-root law on the RMS
    assign sq_in_i[g] = rapd_ms_corr(ms_i[g], s_q.pgain[g], s_q.ios[g]);
    // Extra 2^16 under the root puts 256 counts per sample count
    assign sq_in_v[g] = {ms_v[g], 16'h0000};

    rapd_isqrt u_sq_i (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_start(s_q.tick_d1),
      .i_x(sq_in_i[g]),
      .o_root(root_i[g]),
      .o_done(done_i[g])
    );

    rapd_isqrt u_sq_v (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_start(s_q.tick_d1),
      .i_x(sq_in_v[g]),
      .o_root(root_v[g]),
      .o_done(done_v[g])
    );
  end

  // ==========================================================================
  // Sum-mode terms: B is subtracted from A (and C) in the delta modes
  // ==========================================================================
  // Undefined mode code 3 falls back to the plain sum
  always_comb begin
    term[0] = cur_g[0];
    term[1] = cur_g[1];
    term[2] = cur_g[2];
    case (sum_mode)
      SUM_DIFF_AC: begin
        term[0] = 26'(cur_g[0] - cur_g[1]);
        term[1] = 26'sh0;
        term[2] = 26'(cur_g[2] - cur_g[1]);
      end
      SUM_DIFF_A: begin
        term[0] = 26'(cur_g[0] - cur_g[1]);
        term[1] = 26'sh0;
      end
      default: begin
        term[0] = cur_g[0];
      end
    endcase
  end

  // ==========================================================================
  // Register file, Avalon slave and result capture
  // ==========================================================================
  // One wait state: read data is loaded in the first cycle, the write lands on the accept edge
  always_comb begin
    logic [31:0] rd;
    logic [31:0] sum;
    logic [2:0] h_pg;
    logic [2:0] h_io;
    logic [2:0] h_vg;
    logic [2:0] h_vo;
    logic [2:0] h_ir;
    logic [2:0] h_vr;
    logic [2:0] h_pw;
    rd = 32'h00000000;
    sum = 32'h00000000;
    h_pg = rapd_hit(i_avs.address, OFS_PGAIN);
    h_io = rapd_hit(i_avs.address, OFS_IOS);
    h_vg = rapd_hit(i_avs.address, OFS_PER_PHASE_VOLTAGE_GAIN);
    h_vo = rapd_hit(i_avs.address, OFS_VOS);
    h_ir = rapd_hit(i_avs.address, OFS_CURRENT_RMS_RESULT);
    h_vr = rapd_hit(i_avs.address, OFS_VOLTAGE_RMS_RESULT);
    h_pw = rapd_hit(i_avs.address, OFS_PWR);
    s_d = s_q;

    // Divider and pipeline strobe
    s_d.div = tick ? DIV_RST : 4'(s_q.div + 4'h1);
    s_d.tick_d1 = tick;

    // Bus handshake
    s_d.ack = (i_avs.read || i_avs.write) && !s_q.ack;

    // Read mux; unmapped addresses read zero
    for (int p = 0; p < 3; p++) begin
      if (h_pg[p]) begin
        rd = {20'h00000, s_q.pgain[p]};
      end
      if (h_io[p]) begin
        rd = {20'h00000, s_q.ios[p]};
      end
      if (h_vg[p]) begin
        rd = {20'h00000, s_q.per_phase_voltage_gain[p]};
      end
      if (h_vo[p]) begin
        rd = {20'h00000, s_q.vos[p]};
      end
      if (h_ir[p]) begin
        rd = {8'h00, s_q.current_rms_result[p]};
      end
      if (h_vr[p]) begin
        rd = {8'h00, s_q.voltage_rms_result[p]};
      end
      if (h_pw[p]) begin
        rd = 32'(pwr[p]);
      end
    end
    if (i_avs.address == OFS_MODE) begin
      rd = {24'h000000, s_q.mode};
    end
    if (i_avs.address == OFS_TOTAL) begin
      rd = s_q.total;
    end
    if (i_avs.read && !s_q.ack) begin
      s_d.rdata = rd;
    end

    // Writes to calibration and mode registers; read-only addresses ignore writes
    if (i_avs.write && s_q.ack) begin
      for (int p = 0; p < 3; p++) begin
        if (h_pg[p]) begin
          s_d.pgain[p] = i_avs.writedata[11:0];
        end
        if (h_io[p]) begin
          s_d.ios[p] = i_avs.writedata[11:0];
        end
        if (h_vg[p]) begin
          s_d.per_phase_voltage_gain[p] = i_avs.writedata[11:0];
        end
        if (h_vo[p]) begin
          s_d.vos[p] = i_avs.writedata[11:0];
        end
      end
      if (i_avs.address == OFS_MODE) begin
        s_d.mode = i_avs.writedata[7:0];
      end
    end

    // Total from the freshly filtered phase powers
    for (int p = 0; p < 3; p++) begin
      if (sum_sel[p]) begin
        sum = 32'(sum + 32'(pwr[p]));
      end
    end
    if (s_q.tick_d1) begin
      s_d.total = sum;
    end

    // Roots land when each square root finishes
    for (int p = 0; p < 3; p++) begin
      if (done_i[p]) begin
        s_d.current_rms_result[p] = root_i[p];
      end
      if (done_v[p]) begin
        s_d.voltage_rms_result[p] = rapd_voltage_rms_result_corr(root_v[p], s_q.vos[p]);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.mode <= MODE_RST;
      s_q.div <= DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Wait request drops only in the cycle after a request arrives
  assign o_avs_waitrequest = !s_q.ack;
  assign o_avs_readdata = s_q.rdata;
endmodule

// [rtl/rapd_pkg.sv]
// Shared constants, carriers and arithmetic helpers for the RMS and active power block
package rapd_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ = 50_000_000;              // Master input clock rate
  localparam int RMS_DIV = 12;                     // Results refresh at clock/12
  localparam logic [3:0] DIV_LAST = 4'(RMS_DIV - 1);
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] SQ_CYC = 4'hC;            // 24 root bits, two per cycle

  // ==========================================================================
  // Arithmetic scaling
  // ==========================================================================
  localparam int GAIN_SHIFT = 12;                  // Gain is 1 + code/2^12
  localparam logic signed [13:0] GAIN_ONE = 14'sh1000;
  localparam int IOS_SHIFT = 15;                   // Current offset weight 32768
  localparam int VOS_SHIFT = 6;                    // Voltage offset weight 64
  localparam int VOLTAGE_RMS_RESULT_SHIFT = 16;                  // Root of ms*2^16 gives 256x scale
  localparam int PWR_SHIFT = 12;                   // Product down to 30-bit power word
  localparam int LPF_SHIFT = 8;                    // Pole of the one-pole low-pass

  // ==========================================================================
  // Register map (byte addresses, phases A/B/C at stride 4)
  // ==========================================================================
  localparam logic [7:0] OFS_PGAIN = 8'h00;
  localparam logic [7:0] OFS_IOS = 8'h0C;
  localparam logic [7:0] OFS_PER_PHASE_VOLTAGE_GAIN = 8'h18;
  localparam logic [7:0] OFS_VOS = 8'h24;
  localparam logic [7:0] OFS_MODE = 8'h30;
  localparam logic [7:0] OFS_CURRENT_RMS_RESULT = 8'h40;
  localparam logic [7:0] OFS_VOLTAGE_RMS_RESULT = 8'h4C;
  localparam logic [7:0] OFS_PWR = 8'h58;
  localparam logic [7:0] OFS_TOTAL = 8'h64;

  // Mode register fields and reset values
  localparam int MODE_SUM_LSB = 6;                 // Bits 7-6: sum formula
  localparam int MODE_SEL_A = 5;                   // Bits 5-3: term enables A, B, C
  localparam logic [1:0] SUM_PLAIN = 2'h0;
  localparam logic [1:0] SUM_DIFF_AC = 2'h1;
  localparam logic [1:0] SUM_DIFF_A = 2'h2;
  localparam logic [7:0] MODE_RST = 8'h38;
  localparam logic [11:0] CAL_RST = 12'h000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } rapd_avs_req_t;

  typedef struct packed {
    logic [2:0][23:0] ph;
  } rapd_cur_smp_t;

  typedef struct packed {
    logic [2:0][15:0] ph;
  } rapd_volt_smp_t;

  typedef struct packed {
    logic [3:0] div;
    logic tick_d1;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] mode;
    logic [2:0][11:0] pgain;
    logic [2:0][11:0] ios;
    logic [2:0][11:0] per_phase_voltage_gain;
    logic [2:0][11:0] vos;
    logic [2:0][23:0] current_rms_result;
    logic [2:0][23:0] voltage_rms_result;
    logic [31:0] total;
  } rapd_state_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Scale a sample by 1 + g/2^12
  function automatic logic signed [25:0] rapd_gain_mul(input logic signed [23:0] x, input logic [11:0] g);
    logic signed [13:0] f;
    logic signed [39:0] p;
    f = GAIN_ONE + 14'($signed(g));
    p = 40'(x) * 40'(f);
    return p[GAIN_SHIFT+25:GAIN_SHIFT];
  endfunction

  // Saturate to the 16-bit waveform range
  function automatic logic signed [15:0] rapd_sat16(input logic signed [25:0] x);
    if (!x[25] && (x[24:15] != 10'h000)) begin
      return 16'sh7FFF;
    end
    if (x[25] && (x[24:15] != 10'h3FF)) begin
      return 16'sh8000;
    end
    return x[15:0];
  endfunction

  // Mean square scaled by power gain plus offset*32768, clamped at both ends
  function automatic logic [47:0] rapd_ms_corr(input logic [47:0] ms, input logic [11:0] g,
                                               input logic [11:0] os);
    logic signed [13:0] f;
    logic signed [63:0] t;
    f = GAIN_ONE + 14'($signed(g));
    t = $signed({16'h0000, ms}) * 64'(f);
    t = t >>> GAIN_SHIFT;
    t = t + (64'($signed(os)) <<< IOS_SHIFT);
    if (t[63]) begin
      return 48'h000000000000;
    end
    if (t[62:48] != 15'h0000) begin
      return 48'hFFFFFFFFFFFF;
    end
    return t[47:0];
  endfunction

  // Linear voltage offset of 64 per count, clamped to 24 bits
  function automatic logic [23:0] rapd_voltage_rms_result_corr(input logic [23:0] root, input logic [11:0] os);
    logic signed [25:0] t;
    t = $signed({2'b00, root}) + (26'($signed(os)) <<< VOS_SHIFT);
    if (t[25]) begin
      return 24'h000000;
    end
    if (t[24]) begin
      return 24'hFFFFFF;
    end
    return t[23:0];
  endfunction

  // One-hot phase hit for a group of three word registers
  function automatic logic [2:0] rapd_hit(input logic [7:0] a, input logic [7:0] base);
    logic [2:0] h;
    h = 3'h0;
    for (int p = 0; p < 3; p++) begin
      h[p] = (a == 8'(base + 8'(4 * p)));
    end
    return h;
  endfunction

endpackage

// [rtl/rapd_lpf.sv]
// One-pole low-pass filter that extracts the DC part of a signed stream
`timescale 1ns/100ps
module rapd_lpf #(
  parameter int W = 32                          // Sample and result width
) (
  input wire logic i_clk_sys,                   // Master clock
  input wire logic i_rst_n,                     // Async reset, active low
  input wire logic i_en,                        // One-cycle update strobe
  input wire logic signed [W-1:0] i_x,          // Input sample
  output logic signed [W-1:0] o_y               // Filtered value, from register
);
  import rapd_pkg::*;

  typedef struct packed {
    logic signed [W+LPF_SHIFT-1:0] acc;
  } rapd_lpf_st_t;

  rapd_lpf_st_t s_q, s_d;

  // ==========================================================================
  // Filter step: acc moves 1/256 of the way to the sample
  // ==========================================================================
  // Fraction bits in acc keep small inputs from stalling the filter
  always_comb begin
    s_d = s_q;
    if (i_en) begin
      s_d.acc = s_q.acc + (W+LPF_SHIFT)'(i_x) - (s_q.acc >>> LPF_SHIFT);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_y = s_q.acc[W+LPF_SHIFT-1:LPF_SHIFT];
endmodule

// [rtl/rapd_isqrt.sv]
// Iterative square root of a 48-bit value, two result bits per cycle
`timescale 1ns/100ps
module rapd_isqrt (
  input wire logic i_clk_sys,                   // Master clock
  input wire logic i_rst_n,                     // Async reset, active low
  input wire logic i_start,                     // Load operand, pulse
  input wire logic [47:0] i_x,                  // Operand
  output logic [23:0] o_root,                   // Floor root, from register
  output logic o_done                           // Root updated, pulse
);
  import rapd_pkg::*;

  typedef struct packed {
    logic [25:0] rem;
    logic [23:0] root;
    logic [47:0] x;
    logic [3:0] cnt;
    logic busy;
    logic done;
    logic [23:0] res;
  } rapd_sq_st_t;

  rapd_sq_st_t s_q, s_d;

  // Restoring digit step: returns {remainder, root}
  // Trial operands are two bits wider so near-full-scale roots do not lose the top remainder bits
  function automatic logic [49:0] sq_step(input logic [25:0] r, input logic [23:0] q, input logic [1:0] b);
    logic [27:0] rr;
    logic [27:0] t;
    rr = {r, b};
    t = {2'b00, q, 2'b01};
    if (rr >= t) begin
      return {26'(rr - t), q[22:0], 1'b1};
    end
    return {rr[25:0], q[22:0], 1'b0};
  endfunction

  // ==========================================================================
  // Sequencer: a start restarts even while busy, so a late result is dropped
  // ==========================================================================
  always_comb begin
    logic [49:0] st;
    logic [3:0] c;
    st = '0;
    c = 4'h0;
    s_d = s_q;
    s_d.done = 1'b0;
    if (i_start) begin
      s_d.rem = 26'h0000000;
      s_d.root = 24'h000000;
      s_d.x = i_x;
      c = SQ_CYC;
    end else begin
      c = s_q.cnt;
    end
    if (i_start || s_q.busy) begin
      st = sq_step(s_d.rem, s_d.root, s_d.x[47:46]);
      st = sq_step(st[49:24], st[23:0], s_d.x[45:44]);
      s_d.rem = st[49:24];
      s_d.root = st[23:0];
      s_d.x = {s_d.x[43:0], 4'h0};
      s_d.cnt = 4'(c - 4'h1);
      s_d.busy = (s_d.cnt != 4'h0);
      if (s_d.cnt == 4'h0) begin
        s_d.done = 1'b1;
        s_d.res = st[23:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_root = s_q.res;
  assign o_done = s_q.done;
endmodule

// [tb/rapd_monitor.sv]
// Bus timing and register width checks for the RMS and active power block
`timescale 1ns/100ps
module rapd_monitor (
  input wire logic i_clk_sys,                   // Master clock
  input wire logic i_rst_n,                     // Async reset, active low
  input rapd_pkg::rapd_avs_req_t i_avs,         // Bus request
  input wire logic [31:0] o_avs_readdata,       // Read data
  input wire logic o_avs_waitrequest,           // Wait request
  input rapd_pkg::rapd_cur_smp_t i_cur,         // Current samples
  input rapd_pkg::rapd_volt_smp_t i_volt        // Voltage samples
);
  import rapd_pkg::*;
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Only the first request cycle loads read data, so key on wait high
  logic rd_go;
  logic req;
  assign rd_go = i_avs.read && o_avs_waitrequest;
  assign req = i_avs.read || i_avs.write;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_wait_one_cycle: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait state");
  a_wait_low_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait request low for more than one cycle");
  a_idle_wait_high: assert property (!req && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait request dropped without a request");
  a_rdata_hold: assert property (!rd_go |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  a_cal_width: assert property (rd_go && i_avs.address < OFS_MODE |=> o_avs_readdata[31:12] == 20'h00000)
    else $error("calibration read wider than 12 bits");
  a_mode_width: assert property (rd_go && i_avs.address == OFS_MODE |=> o_avs_readdata[31:8] == 24'h000000)
    else $error("mode read wider than 8 bits");
  a_rms_width: assert property (rd_go && i_avs.address inside {[OFS_CURRENT_RMS_RESULT:8'h54]} ##1 1'b1
                                |-> o_avs_readdata[31:24] == 8'h00)
    else $error("rms read wider than 24 bits");
  a_power_sext: assert property (rd_go && i_avs.address inside {[OFS_PWR:8'h60]}
                                 |=> o_avs_readdata[31:29] inside {3'h0, 3'h7})
    else $error("phase power not sign extended");
  a_unmapped_zero: assert property (rd_go && i_avs.address == 8'h3C |=> o_avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

bind rapd_top rapd_monitor u_mon (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_cur(i_cur),
  .i_volt(i_volt)
);

// [tb/tb.sv]
// Self-checking testbench for the RMS and active power block
`timescale 1ns/100ps
module tb;
  import rapd_pkg::*;
  // ==========================================================================
  // Clock, reset and stimulus
  // ==========================================================================
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  rapd_avs_req_t avs = '0;
  rapd_cur_smp_t cur;
  rapd_volt_smp_t volt;
  logic [31:0] rdata;
  logic wait_req;
  logic [31:0] got;
  int num_errors = 0;
  int checked = 0;

  // Free-running 50 MHz clock
  always #10 i_clk_sys = ~i_clk_sys;

  rapd_top DUT (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_avs(avs),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req),
    .i_cur(cur),
    .i_volt(volt)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic err(input string m);
    num_errors++;
    $display("Error at %0t ns: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t ns: read %h expected %h", $time, g, e);
    end
  endtask

  // One Avalon access; request held until wait is seen low at an edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    avs.address <= a;
    avs.read <= !wr;
    avs.write <= wr;
    avs.writedata <= d;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    q = rdata;
    if (n >= 100) begin
      err("bus access never answered");
    end
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask

  // Results settle through the low-pass filters, so reread until a bound
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    int k;
    k = 0;
    do begin
      bus(a, 1'b0, 32'h0, got);
      k++;
    end while (got !== e && k < 20000);
    chk(got, e);
  endtask

  task automatic step(input logic [7:0] wa, input logic [31:0] wd, input logic [7:0] ra, input logic [31:0] e);
    bus(wa, 1'b1, wd, got);
    poll(ra, e);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well above the expected settling time
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    err("watchdog expired");
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    // Constant samples keep the filter settle points exact
    cur.ph[0] = 24'h000040;
    cur.ph[1] = 24'hFFFFC0;
    cur.ph[2] = 24'h000080;
    volt.ph[0] = 16'h0040;
    volt.ph[1] = 16'h0040;
    volt.ph[2] = 16'h0040;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Reset values and 12-bit write-back with upper bits ignored
    for (int i = 0; i < 12; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0, got);
      chk(got, {20'h0, CAL_RST});
      bus(8'(4 * i), 1'b1, 32'hFFFFFA50 + 32'(i), got);
      bus(8'(4 * i), 1'b0, 32'h0, got);
      chk(got, 32'h00000A50 + 32'(i));
      bus(8'(4 * i), 1'b1, 32'h0, got);
    end
    bus(OFS_MODE, 1'b0, 32'h0, got);
    chk(got, {24'h0, MODE_RST});
    step(OFS_PER_PHASE_VOLTAGE_GAIN + 8'h04, 32'hFFFFF7FF, OFS_PER_PHASE_VOLTAGE_GAIN + 8'h04, 32'h7FF);
    step(OFS_PER_PHASE_VOLTAGE_GAIN + 8'h08, 32'h800, OFS_PER_PHASE_VOLTAGE_GAIN + 8'h08, 32'h800);
    // Voltage rms: 64 counts give 64*256, gains scale by 1.5 and 0.5
    poll(OFS_VOLTAGE_RMS_RESULT, 32'd16384);
    poll(OFS_VOLTAGE_RMS_RESULT + 8'h04, 32'd24320);
    poll(OFS_VOLTAGE_RMS_RESULT + 8'h08, 32'd8192);
    poll(OFS_CURRENT_RMS_RESULT + 8'h08, 32'd128);
    poll(OFS_CURRENT_RMS_RESULT + 8'h04, 32'd64);
    // Current rms gain and offset on phase A
    step(OFS_PGAIN, 32'h7FF, OFS_CURRENT_RMS_RESULT, 32'd78);
    step(OFS_PGAIN, 32'h800, OFS_CURRENT_RMS_RESULT, 32'd45);
    step(OFS_PGAIN, 32'h000, OFS_CURRENT_RMS_RESULT, 32'd64);
    step(OFS_IOS, 32'h001, OFS_CURRENT_RMS_RESULT, 32'd192);
    step(OFS_IOS, 32'hFFF, OFS_CURRENT_RMS_RESULT, 32'd0);
    step(OFS_IOS, 32'h000, OFS_CURRENT_RMS_RESULT, 32'd64);
    // Voltage rms offset, linear at 64 per count
    step(OFS_VOS, 32'h7FF, OFS_VOLTAGE_RMS_RESULT, 32'd147392);
    step(OFS_VOS, 32'hFFF, OFS_VOLTAGE_RMS_RESULT, 32'd16320);
    step(OFS_VOS, 32'hEFF, OFS_VOLTAGE_RMS_RESULT, 32'd0);
    step(OFS_VOS, 32'h000, OFS_VOLTAGE_RMS_RESULT, 32'd16384);
    step(OFS_VOLTAGE_RMS_RESULT, 32'h0, OFS_VOLTAGE_RMS_RESULT, 32'd16384);
    // Total power over term enables and sum modes
    poll(OFS_TOTAL, 32'd2);
    step(OFS_MODE, 32'h20, OFS_TOTAL, 32'd1);
    step(OFS_MODE, 32'h10, OFS_TOTAL, 32'hFFFFFFFF);
    step(OFS_MODE, 32'h08, OFS_TOTAL, 32'd2);
    step(OFS_MODE, 32'h00, OFS_TOTAL, 32'd0);
    step(OFS_MODE, 32'h78, OFS_TOTAL, 32'd5);
    step(OFS_MODE, 32'hB8, OFS_TOTAL, 32'd4);
    step(OFS_MODE, 32'hF8, OFS_TOTAL, 32'd2);
    // Phase powers; the unmapped write must change nothing
    step(8'h3C, 32'hFFFFFFFF, OFS_PWR, 32'd1);
    poll(OFS_PWR + 8'h04, 32'hFFFFFFFF);
    poll(OFS_PWR + 8'h08, 32'd2);
    bus(8'h3C, 1'b0, 32'h0, got);
    chk(got, 32'h0);
    end_sim();
  end
endmodule
